//--- shared/msfs_pkg.sv
// constants, register map and carrier types of the multi-speed frequency selector
package msfs_pkg;
  // frequencies in 0.01 Hz units, times in 0.1 s units
  localparam logic [15:0] FREQ_MAX       = 16'h9C40;  // 400.00 Hz
  localparam logic [15:0] FREQ_NOT_SEL   = 16'h270F;  // 9999 marker
  localparam logic [15:0] HIGH_RST       = 16'h1770;  // 60.00 Hz
  localparam logic [15:0] MID_RST        = 16'h0BB8;  // 30.00 Hz
  localparam logic [15:0] LOW_RST        = 16'h03E8;  // 10.00 Hz
  localparam logic [15:0] INCH_RST       = 16'h01F4;  // 5.00 Hz
  localparam logic [15:0] INCH_RAMP_RST  = 16'h0005;  // 0.5 s
  localparam logic [15:0] INCH_RAMP_MAX  = 16'h8CA0;  // 3600.0 s
  localparam logic [15:0] RAMP_REF_RST   = 16'h1770;  // 60.00 Hz
  localparam logic [15:0] BOOST_RST      = 16'h0000;
  // terminal function codes
  localparam logic [3:0] FN_LOW    = 4'h0;
  localparam logic [3:0] FN_MID    = 4'h1;
  localparam logic [3:0] FN_HIGH   = 4'h2;
  localparam logic [3:0] FN_SECOND = 4'h3;
  localparam logic [3:0] FN_INCH   = 4'h5;
  localparam logic [3:0] FN_EXT    = 4'h8;
  localparam int          NUM_TERM = 5;
  localparam logic [19:0] TERM_MAP_RST = 20'h0_5210;  // t0 low, t1 mid, t2 high, t3 inch, t4 low
  localparam logic [2:0] MODE_EXT  = 3'h3;
  localparam logic [2:0] MODE_COMB = 3'h4;
  // register byte offsets
  localparam logic [7:0] A_HIGH     = 8'h00;
  localparam logic [7:0] A_MID      = 8'h04;
  localparam logic [7:0] A_LOW      = 8'h08;
  localparam logic [7:0] A_INCH     = 8'h0C;
  localparam logic [7:0] A_RAMP     = 8'h10;
  localparam logic [7:0] A_RAMPREF  = 8'h14;
  localparam logic [7:0] A_BOOST    = 8'h18;  // [15:0] primary, [31:16] second
  localparam logic [7:0] A_CTRL     = 8'h1C;  // [1:0] load pattern, [4:2] mode, [5] remote, [6] flux
  localparam logic [7:0] A_TERM     = 8'h20;  // 5 x 4-bit function codes
  localparam logic [7:0] A_STATUS   = 8'h24;
  localparam logic [7:0] A_FREQOUT  = 8'h28;  // [15:0] freq, [31:16] boost
  localparam logic [7:0] A_SPEED0   = 8'h40;  // speeds 4..15 at 0x40..0x6C
  localparam logic [7:0] A_LUT      = 8'h70;  // 8 x 4-bit, lower half of the combination table: combination -> speed number
  localparam logic [7:0] A_LUT_HI   = 8'h74;  // upper half of the combination table
  // default table: index = {ext,high,mid,low}; entries 8..15 pick speed 8..15
  localparam logic [63:0] LUT_RST   = 64'hFEDC_BA98_7654_3210;
  localparam logic [1:0] LP_FWD_ONLY = 2'h2;
  localparam logic [1:0] LP_REV_ONLY = 2'h3;

  typedef enum logic [1:0] {
    MSFS_SRC_NONE = 2'b00,
    MSFS_SRC_INCH = 2'b01,
    MSFS_SRC_MULTI = 2'b10,
    MSFS_SRC_ANALOG = 2'b11
  } msfs_src_t;

  typedef struct packed {
    logic high;
    logic mid;
    logic low;
    logic ext;
    logic second;
    logic inch;
  } msfs_sel_t;
endpackage

//--- hdl/msfs_top.sv
// multi-speed frequency selector with apb register file
`timescale 1ns/1ps
module msfs_top (
  input  wire logic        MCLK_I,
  input  wire logic        SRST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic [4:0]  TERM_I,
  input  wire logic        FORWARD_START_INPUT_I,
  input  wire logic        REVERSE_START_INPUT_I,
  input  wire logic [15:0] CURRENT_ANALOG_FREQ_I,
  input  wire logic        CURRENT_ANALOG_VALID_I,
  input  wire logic [15:0] VOLTAGE_ANALOG_FREQ_I,
  input  wire logic        VOLTAGE_ANALOG_VALID_I,
  output logic      [15:0] TARGET_FREQ_O,
  output logic      [15:0] RAMP_TIME_O,
  output logic      [15:0] RAMP_REF_FREQ_O,
  output logic      [15:0] TORQUE_BOOST_O,
  output logic             RUN_O,
  output logic             REVERSE_O,
  output logic      [1:0]  SOURCE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // settings
  logic [15:0] high_set;
  logic [15:0] mid_set;
  logic [15:0] low_set;
  logic [15:0] inch_set;
  logic [15:0] ramp_set;
  logic [15:0] rampref_set;
  logic [15:0] boost1;
  logic [15:0] boost2;
  logic [1:0]  load_pattern;
  logic [2:0]  op_mode;
  logic        remote_on;
  logic        flux_mode;
  logic [19:0] term_map;
  logic [63:0] speed_lut;
  logic [15:0] speed_set [4:15];

  // clamp a written frequency into 0..400 Hz, keeping the 9999 marker if allowed
  function automatic logic [15:0] clamp_freq(input logic [15:0] v, input logic allow_ns);
    if (allow_ns && v == msfs_pkg::FREQ_NOT_SEL) begin
      clamp_freq = v;
    end else if (v > msfs_pkg::FREQ_MAX) begin
      clamp_freq = msfs_pkg::FREQ_MAX;
    end else begin
      clamp_freq = v;
    end
  endfunction

  // true when any terminal carries the given function code and is asserted
  function automatic logic term_fn(input logic [19:0] map, input logic [4:0] t,
                                   input logic [3:0] code);
    term_fn = 1'b0;
    for (int i = 0; i < msfs_pkg::NUM_TERM; i++) begin
      if (map[i*4 +: 4] == code && t[i]) begin
        term_fn = 1'b1;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, unmapped offsets answer with pslverr
  wire        acc      = PSEL_I && PENABLE_I;
  wire        wr       = acc && PWRITE_I;
  wire        in_speed = PADDR_I >= msfs_pkg::A_SPEED0 && PADDR_I < msfs_pkg::A_LUT &&
                         PADDR_I[1:0] == 2'b00;
  wire [3:0]  spd_idx  = 4'(PADDR_I[5:2] + 4'h4);  // 0x40 -> speed 4
  wire        mapped   = in_speed || (PADDR_I <= msfs_pkg::A_FREQOUT && PADDR_I[1:0] == 2'b00)
                         || PADDR_I == msfs_pkg::A_LUT || PADDR_I == msfs_pkg::A_LUT_HI;

  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = acc && !mapped;

  // writes accepted at any time, running or not, no write-lock state exists
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      high_set     <= msfs_pkg::HIGH_RST;
      mid_set      <= msfs_pkg::MID_RST;
      low_set      <= msfs_pkg::LOW_RST;
      inch_set     <= msfs_pkg::INCH_RST;
      ramp_set     <= msfs_pkg::INCH_RAMP_RST;
      rampref_set  <= msfs_pkg::RAMP_REF_RST;
      boost1       <= msfs_pkg::BOOST_RST;
      boost2       <= msfs_pkg::BOOST_RST;
      load_pattern <= 2'h0;
      op_mode      <= msfs_pkg::MODE_EXT;
      remote_on    <= 1'b0;
      flux_mode    <= 1'b0;
      term_map     <= msfs_pkg::TERM_MAP_RST;
      speed_lut    <= msfs_pkg::LUT_RST;
      for (int i = 4; i <= 15; i++) begin
        speed_set[i] <= msfs_pkg::FREQ_NOT_SEL;
      end
    end else if (wr) begin
      case (PADDR_I)
        msfs_pkg::A_HIGH:    high_set    <= clamp_freq(PWDATA_I[15:0], 1'b0);
        msfs_pkg::A_MID:     mid_set     <= clamp_freq(PWDATA_I[15:0], 1'b0);
        msfs_pkg::A_LOW:     low_set     <= clamp_freq(PWDATA_I[15:0], 1'b0);
        msfs_pkg::A_INCH:    inch_set    <= clamp_freq(PWDATA_I[15:0], 1'b0);
        msfs_pkg::A_RAMP:    ramp_set    <= (PWDATA_I[15:0] > msfs_pkg::INCH_RAMP_MAX) ?
                                            msfs_pkg::INCH_RAMP_MAX : PWDATA_I[15:0];
        msfs_pkg::A_RAMPREF: rampref_set <= clamp_freq(PWDATA_I[15:0], 1'b0);
        msfs_pkg::A_BOOST: begin
          boost1 <= PWDATA_I[15:0];
          boost2 <= PWDATA_I[31:16];
        end
        msfs_pkg::A_CTRL: begin
          load_pattern <= PWDATA_I[1:0];
          op_mode      <= PWDATA_I[4:2];
          remote_on    <= PWDATA_I[5];
          flux_mode    <= PWDATA_I[6];
        end
        msfs_pkg::A_TERM:    term_map        <= PWDATA_I[19:0];
        msfs_pkg::A_LUT:     speed_lut[31:0] <= PWDATA_I;
        msfs_pkg::A_LUT_HI:  speed_lut[63:32] <= PWDATA_I;
        default: begin
          if (in_speed) begin
            speed_set[spd_idx] <= clamp_freq(PWDATA_I[15:0], 1'b1);
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // terminal routing
  // a net, so each field may carry its own continuous assignment
  wire msfs_pkg::msfs_sel_t sel;
  assign sel.low    = term_fn(term_map, TERM_I, msfs_pkg::FN_LOW);
  assign sel.mid    = term_fn(term_map, TERM_I, msfs_pkg::FN_MID);
  assign sel.high   = term_fn(term_map, TERM_I, msfs_pkg::FN_HIGH);
  assign sel.second = term_fn(term_map, TERM_I, msfs_pkg::FN_SECOND);
  assign sel.inch   = term_fn(term_map, TERM_I, msfs_pkg::FN_INCH);
  assign sel.ext    = term_fn(term_map, TERM_I, msfs_pkg::FN_EXT);

  ////////////////////////////////////////////////////////////////////////////
  // multi-speed selection
  wire [3:0]  combo     = {sel.ext, sel.high, sel.mid, sel.low};
  wire [3:0]  lut_speed = speed_lut[combo*4 +: 4];
  wire        ext_speed = sel.ext && lut_speed >= 4'h4;
  wire [15:0] ext_freq  = ext_speed ? speed_set[lut_speed] : msfs_pkg::FREQ_NOT_SEL;
  wire        ext_valid = ext_speed && ext_freq != msfs_pkg::FREQ_NOT_SEL;
  // speed 8 unset with only extension on falls back to low speed
  wire        ext_only  = sel.ext && !sel.high && !sel.mid && !sel.low;
  wire        ext_low   = ext_only && !ext_valid;
  // lowest asserted select wins among the three basic ones
  wire [15:0] three_freq = sel.low ? low_set : (sel.mid ? mid_set : high_set);
  wire        three_any  = sel.low || sel.mid || sel.high;
  // remote function reassigns the selects, so multi-speed is blocked
  wire        multi_ok  = (op_mode == msfs_pkg::MODE_EXT || op_mode == msfs_pkg::MODE_COMB)
                          && !remote_on;
  wire        multi_act = multi_ok && (ext_valid || ext_low || three_any);
  wire [15:0] multi_freq = ext_valid ? ext_freq : (ext_low ? low_set : three_freq);

  ////////////////////////////////////////////////////////////////////////////
  // source priority and run control
  wire start_any = FORWARD_START_INPUT_I || REVERSE_START_INPUT_I;
  wire reverse   = REVERSE_START_INPUT_I && !FORWARD_START_INPUT_I;
  msfs_pkg::msfs_src_t src;
  logic [15:0]         next_freq;
  always_comb begin
    src       = msfs_pkg::MSFS_SRC_NONE;
    next_freq = 16'h0000;
    if (sel.inch) begin
      src       = msfs_pkg::MSFS_SRC_INCH;
      next_freq = inch_set;
    end else if (multi_act) begin
      src       = msfs_pkg::MSFS_SRC_MULTI;
      next_freq = multi_freq;
    end else if (CURRENT_ANALOG_VALID_I) begin
      src       = msfs_pkg::MSFS_SRC_ANALOG;
      next_freq = CURRENT_ANALOG_FREQ_I;
    end else if (VOLTAGE_ANALOG_VALID_I) begin
      src       = msfs_pkg::MSFS_SRC_ANALOG;
      next_freq = VOLTAGE_ANALOG_FREQ_I;
    end
  end

  // boost selection by second function and load pattern
  wire [15:0] boost_base = sel.second ? boost2 : boost1;
  logic [15:0] next_boost;
  always_comb begin
    next_boost = boost_base;
    if (!flux_mode) begin
      if (load_pattern == msfs_pkg::LP_FWD_ONLY && reverse) begin
        next_boost = 16'h0000;
      end else if (load_pattern == msfs_pkg::LP_REV_ONLY && !reverse) begin
        next_boost = 16'h0000;
      end
    end
  end

  // outputs registered; inching runs only while a start input is held
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      TARGET_FREQ_O   <= 16'h0000;
      RAMP_TIME_O     <= msfs_pkg::INCH_RAMP_RST;
      RAMP_REF_FREQ_O <= msfs_pkg::RAMP_REF_RST;
      TORQUE_BOOST_O  <= 16'h0000;
      RUN_O           <= 1'b0;
      REVERSE_O       <= 1'b0;
      SOURCE_O        <= 2'b00;
    end else begin
      TARGET_FREQ_O   <= next_freq;
      RAMP_TIME_O     <= ramp_set;
      RAMP_REF_FREQ_O <= rampref_set;
      TORQUE_BOOST_O  <= next_boost;
      RUN_O           <= start_any && src != msfs_pkg::MSFS_SRC_NONE;
      REVERSE_O       <= reverse;
      SOURCE_O        <= src;
    end
  end

  // read mux
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    case (PADDR_I)
      msfs_pkg::A_HIGH:    rdata = {16'h0000, high_set};
      msfs_pkg::A_MID:     rdata = {16'h0000, mid_set};
      msfs_pkg::A_LOW:     rdata = {16'h0000, low_set};
      msfs_pkg::A_INCH:    rdata = {16'h0000, inch_set};
      msfs_pkg::A_RAMP:    rdata = {16'h0000, ramp_set};
      msfs_pkg::A_RAMPREF: rdata = {16'h0000, rampref_set};
      msfs_pkg::A_BOOST:   rdata = {boost2, boost1};
      msfs_pkg::A_CTRL:    rdata = {25'h0, flux_mode, remote_on, op_mode, load_pattern};
      msfs_pkg::A_TERM:    rdata = {12'h000, term_map};
      msfs_pkg::A_STATUS:  rdata = {24'h0, SOURCE_O, REVERSE_O, RUN_O, 4'h0};
      msfs_pkg::A_FREQOUT: rdata = {TORQUE_BOOST_O, TARGET_FREQ_O};
      msfs_pkg::A_LUT:     rdata = speed_lut[31:0];
      msfs_pkg::A_LUT_HI:  rdata = speed_lut[63:32];
      default: begin
        if (in_speed) begin
          rdata = {16'h0000, speed_set[spd_idx]};
        end
      end
    endcase
  end

  // read data captured in the setup cycle, valid through the access phase
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= rdata;
    end
  end

endmodule // msfs_top

//--- tb/msfs_chk.sv
// concurrent checks on the selector's top-level ports
`timescale 1ns/1ps
module msfs_chk (
  input wire logic        MCLK_I,
  input wire logic        SRST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        FORWARD_START_INPUT_I,
  input wire logic        REVERSE_START_INPUT_I,
  input wire logic [15:0] CURRENT_ANALOG_FREQ_I,
  input wire logic        CURRENT_ANALOG_VALID_I,
  input wire logic [15:0] VOLTAGE_ANALOG_FREQ_I,
  input wire logic        VOLTAGE_ANALOG_VALID_I,
  input wire logic [15:0] TARGET_FREQ_O,
  input wire logic [15:0] RAMP_TIME_O,
  input wire logic [15:0] RAMP_REF_FREQ_O,
  input wire logic        RUN_O,
  input wire logic [1:0]  SOURCE_O
);
  // one clock domain, so clocking and reset are declared once
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  ////////////////////////////////////////////////////////////
  // bus answers: zero wait, error only in access to a hole
  apb_ready_a: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
    else $error("pready low in access");
  hole_err_a: assert property (PSEL_I && PENABLE_I && PADDR_I == 8'h3C |-> PSLVERR_O)
    else $error("no error on unmapped access");
  err_setup_a: assert property (!PENABLE_I |-> !PSLVERR_O)
    else $error("error outside access");
  // run needs a held start and a live command source
  run_start_a: assert property (!$past(FORWARD_START_INPUT_I || REVERSE_START_INPUT_I)
    |-> !RUN_O)
    else $error("running without start");
  run_src_a: assert property (RUN_O |-> SOURCE_O != 2'h0)
    else $error("running with no source");
  freq_max_a: assert property (TARGET_FREQ_O <= msfs_pkg::FREQ_MAX)
    else $error("target above ceiling");
  // analog order: current input beats voltage input
  cur_pick_a: assert property (SOURCE_O == 2'h3 && $past(CURRENT_ANALOG_VALID_I)
    |-> TARGET_FREQ_O == $past(CURRENT_ANALOG_FREQ_I))
    else $error("current input not taken");
  vol_pick_a: assert property (SOURCE_O == 2'h3 && !$past(CURRENT_ANALOG_VALID_I)
    |-> $past(VOLTAGE_ANALOG_VALID_I) && TARGET_FREQ_O == $past(VOLTAGE_ANALOG_FREQ_I))
    else $error("voltage input not taken");
  ramp_rst_a: assert property ($fell(SRST_I) |-> RAMP_TIME_O == msfs_pkg::INCH_RAMP_RST
    && RAMP_REF_FREQ_O == msfs_pkg::RAMP_REF_RST)
    else $error("ramp outputs not at default");
  inch_c: cover property (SOURCE_O == 2'h1 && RUN_O);
  multi_c: cover property (SOURCE_O == 2'h2 && RUN_O);
  analog_c: cover property (SOURCE_O == 2'h3);
endmodule // msfs_chk

//--- tb/msfs_panel.sv
// contact switch and panel model standing in front of the selector
`timescale 1ns/1ps
module msfs_panel (
  input  wire logic        clk_i,
  output logic      [4:0]  term_o,
  output logic             fwd_o,
  output logic             rev_o,
  output logic      [15:0] cur_o,
  output logic             cur_v_o,
  output logic      [15:0] vol_o,
  output logic             vol_v_o
);
  // all contacts open at power up
  initial {term_o, fwd_o, rev_o, cur_o, cur_v_o, vol_o, vol_v_o} = '0;
  // contacts move together just after an edge, as a real panel scan would
  task automatic put(input logic [4:0] t, input logic f, input logic r,
                     input logic [15:0] c, input logic cv, input logic [15:0] v,
                     input logic vv);
    @(posedge clk_i);
    term_o  <= t;
    fwd_o   <= f;
    rev_o   <= r;
    cur_o   <= c;
    cur_v_o <= cv;
    vol_o   <= v;
    vol_v_o <= vv;
  endtask
endmodule // msfs_panel

//--- tb/tb.sv
// self-checking bench for the multi-speed frequency selector
`timescale 1ns/1ps
module tb;
  logic        mclk, srst, psel, pen, pwr, rdy, serr, fwd, rvs, cv, vv, run, rvo;
  logic [7:0]  padr;
  logic [31:0] pwd, prd;
  logic [4:0]  term;
  logic [15:0] cur, vol, freq, rtime, rref, bst;
  logic [1:0]  src;
  logic [32:0] got;
  int          err_count = 0, n_checks = 0, cyc = 0, seed = 61, k;
  int          mreg [int];
  msfs_top dut_u (.MCLK_I(mclk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy),
    .PSLVERR_O(serr), .TERM_I(term), .FORWARD_START_INPUT_I(fwd),
    .REVERSE_START_INPUT_I(rvs), .CURRENT_ANALOG_FREQ_I(cur), .CURRENT_ANALOG_VALID_I(cv),
    .VOLTAGE_ANALOG_FREQ_I(vol), .VOLTAGE_ANALOG_VALID_I(vv), .TARGET_FREQ_O(freq),
    .RAMP_TIME_O(rtime), .RAMP_REF_FREQ_O(rref), .TORQUE_BOOST_O(bst), .RUN_O(run),
    .REVERSE_O(rvo), .SOURCE_O(src));
  msfs_panel pan_u (.clk_i(mclk), .term_o(term), .fwd_o(fwd), .rev_o(rvs), .cur_o(cur),
    .cur_v_o(cv), .vol_o(vol), .vol_v_o(vv));
  ////////////////////////////////////////////////////////////
  // clock and hang guard; the ceiling is far above the few hundred cycles used
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 5000) begin
      err_count++;
      give_verdict();
    end
  end
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk_out(input logic [35:0] g, input logic [35:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk_reg(input logic [32:0] g, input logic [32:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // apb master: request held until pready is seen high; model follows mapped writes
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; padr <= a; pwd <= d;
    @(posedge mclk);
    pen <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (rdy !== 1'b1);
    got = {serr, prd};
    psel <= 1'b0; pen <= 1'b0;
    if (w && mreg.exists(a)) mreg[a] = d;
  endtask
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk_reg(got, {!mreg.exists(a), mreg.exists(a) ? 32'(mreg[a]) : 32'h0});
  endtask
  // reference model: {source, run, reverse, boost, frequency}
  function automatic logic [35:0] m_out(input logic [4:0] t, input logic f, input logic r);
    int c, h, m, l, x, j, s2, i, fr, sr, b;
    c = mreg[8'h1C]; {h, m, l, x, j, s2, fr, sr} = '0;
    for (i = 0; i < 5; i++) if (t[i]) case (mreg[8'h20] >> 4 * i & 15)
      0: l = 1; 1: m = 1; 2: h = 1; 3: s2 = 1; 5: j = 1; 8: x = 1; default: ;
    endcase
    if (j) begin sr = 1; fr = mreg[8'h0C]; end
    else if ((c >> 2 & 7) > 2 && (c >> 2 & 7) < 5 && !(c & 32) && (h | m | l | x)) begin
      sr = 2;
      fr = l ? mreg[8'h08] : m ? mreg[8'h04] : h ? mreg[8'h00] : mreg[8'h08];
      i = 8'h40 + 4 * (x * 8 + h * 4 + m * 2 + l - 4);
      if (x && mreg[i] != 16'h270F) fr = mreg[i];
    end
    else if (cv) begin sr = 3; fr = cur; end
    else if (vv) begin sr = 3; fr = vol; end
    b = s2 ? mreg[8'h18] >> 16 : mreg[8'h18] & 16'hFFFF;
    if (!(c & 64) && ((c & 3) == 2 && r && !f || (c & 3) == 3 && !(r && !f))) b = 0;
    return {sr[1:0], (f | r) && sr != 0, r && !f, b[15:0], fr[15:0]};
  endfunction
  // contacts plus random analog commands, settled outputs compared two cycles later
  task step(input logic [4:0] t, input logic f, input logic r);
    pan_u.put(t, f, r, 16'({$random(seed)} % 40001), 1'($random(seed)),
              16'({$random(seed)} % 40001), 1'($random(seed)));
    repeat (2) @(posedge mclk);
    #1 chk_out({src, run, rvo, bst, freq}, m_out(t, f, r));
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {psel, pen, pwr, padr, pwd} = '0;
    srst = 1'b1;
    {mreg[8'h00], mreg[8'h04], mreg[8'h08]} = {32'h1770, 32'h0BB8, 32'h03E8};
    {mreg[8'h0C], mreg[8'h10], mreg[8'h14], mreg[8'h18]} = {32'h01F4, 32'h5, 32'h1770, 32'h0};
    {mreg[8'h1C], mreg[8'h20]} = {32'h0000_000C, 32'h0000_5210};
    {mreg[8'h70], mreg[8'h74]} = {32'h7654_3210, 32'hFEDC_BA98};
    for (k = 8'h40; k < 8'h70; k += 4) mreg[k] = 32'h270F;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    #1 chk_out({rtime, rref}, {16'h0005, 16'h1770});
    foreach (mreg[a]) rd(a[7:0]);
    apb(1'b1, 8'h3C, 32'h1234_5678);
    rd(8'h3C);
    $display("register defaults done");
    for (k = 1; k < 8; k++) step(k[4:0], k[0], 1'b0);
    step(5'h0C, 1'b1, 1'b0);
    step(5'h08, 1'b0, 1'b1);
    step(5'h08, 1'b0, 1'b0);
    repeat (4) step(5'h00, 1'b1, 1'b0);
    $display("speed, inching and analog done");
    apb(1'b1, 8'h20, 32'h0008_5210);
    step(5'h10, 1'b1, 1'b0);
    apb(1'b1, 8'h50, 32'h0000_1234);
    step(5'h10, 1'b1, 1'b0);
    $display("extension speeds done");
    for (k = 0; k < 3; k++) begin
      apb(1'b1, 8'h1C, k == 0 ? 32'h4 : k == 1 ? 32'h10 : 32'h2C);
      step(5'h04, 1'b1, 1'b0);
    end
    $display("mode gating done");
    apb(1'b1, 8'h18, 32'h0200_0100);
    apb(1'b1, 8'h20, 32'h0003_5210);
    for (k = 0; k < 4; k++) begin
      apb(1'b1, 8'h1C, {25'h0, k[1], 1'b0, 3'h3, 1'b1, k[0]});
      step(5'h00, 1'b1, 1'b0);
      step(5'h00, 1'b0, 1'b1);
      step(5'h10, 1'b0, 1'b1);
    end
    rd(8'h18);
    $display("torque boost done");
    give_verdict();
  end
endmodule // tb
// checker attached beside the top module's ports
bind msfs_top msfs_chk chk_u (.MCLK_I, .SRST_I, .PSEL_I, .PENABLE_I, .PADDR_I, .PREADY_O,
  .PSLVERR_O, .FORWARD_START_INPUT_I, .REVERSE_START_INPUT_I, .CURRENT_ANALOG_FREQ_I,
  .CURRENT_ANALOG_VALID_I, .VOLTAGE_ANALOG_FREQ_I, .VOLTAGE_ANALOG_VALID_I,
  .TARGET_FREQ_O, .RAMP_TIME_O, .RAMP_REF_FREQ_O, .RUN_O, .SOURCE_O);
